// *** verilog/ipc_pkg.sv ***
package ipc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 125;
  localparam int LIMIT_NS = 4000;
  // longest time: rounds down, never below one cycle
  localparam int LIMIT_CYC_I = (LIMIT_NS * CLK_MHZ / 1000) < 1 ? 1 : (LIMIT_NS * CLK_MHZ / 1000);
  localparam logic [8:0] LIMIT_CYC = 9'(LIMIT_CYC_I);

  // ==========================================================
  // tick positions inside one bit period
  localparam logic [3:0] TX_LATCH_TICK = 4'h2;
  localparam logic [3:0] TX_PULSE_FIRST = 4'h7;
  localparam logic [3:0] TX_PULSE_LAST = 4'h9;
  localparam logic [3:0] RX_WINDOW_LAST = 4'h3;
  localparam logic [3:0] RX_OUT_TICK = 4'h4;

  // ==========================================================
  // reset values of the pins
  localparam logic HOST_OUT_RST = 1'b1;
  localparam logic IR_OUT_RST = 1'b0;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    IPC_IDLE = 3'b001,
    IPC_TX = 3'b010,
    IPC_RX = 3'b100
  } ipc_mode_t;

  typedef struct packed {
    logic clk16;
    logic host_in;
    logic ir_in;
  } ipc_pins_t;

  typedef struct packed {
    ipc_mode_t mode;
    logic clk_prev;
    logic [3:0] tick;
    logic [3:0] bits;
    logic bit_val;
    logic seen_low;
    logic [8:0] lim;
    logic ir_out;
    logic host_out;
  } ipc_state_t;

endpackage

// *** verilog/ipc_sync.sv ***
`timescale 1ns/10ps

// two-flop synchroniser, one lane per bit
module ipc_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // ipc_sync

// *** verilog/ipc_codec.sv ***
`timescale 1ns/10ps

// Notes on behaviour
// [R1] host input falling starts an ir pulse seven to eight ticks later
// [R2] ir input falling drives host output low four ticks later
// [R3] all timing steps on edges of the sixteen-times clock input only; the limiter counts CLK cycles instead
// [R4] every bit period is sixteen ticks, for start, eight data and stop bits
// [R5] clock source changes frequency only between stop bit and next start bit
// [R6] clock runs steadily whenever ir reception may occur
// [R7] clock may stop when reception is unwanted; no timing activity then
// [R8] clock is sixteen times the baud rate shared by host and link
// [R9] low bit: ir output low seven ticks, high three, then low
// [R10] high bit: ir output low for all sixteen ticks
// [R11] limiter ends any ir high pulse after about four microseconds
// [R12] received low bit is low first three ticks; high bit stays high
// [R13] host output holds each decoded bit for one whole bit period
// [R14] in reset host output is high and ir output is low
// [R15] reset stops the state machine for low power
// [R16] ir output is suppressed while ir input receives a low pulse
// [R17] after a start edge each following bit sits sixteen ticks later
// [R18] host and ir inputs are synchronised before edge detection
module ipc_codec #(
  parameter int TICKS_PER_BIT = 16,
  parameter int BITS_PER_FRAME = 10
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // sixteen-times bit clock
  input wire logic SIXTEEN_TIMES_CLOCK_IN,
  // host uart side
  input wire logic HOST_TXD_IN,
  output logic HOST_RXD_OUT,
  // infrared transceiver side
  input wire logic IR_PULSE_IN,
  output logic IR_PULSE_OUT
);

  // ==========================================================
  // elaboration checks
  if (TICKS_PER_BIT < 10 || TICKS_PER_BIT > 16) begin : g_bad_ticks
    $error("TICKS_PER_BIT must lie in 10..16");
  end
  if (BITS_PER_FRAME < 2 || BITS_PER_FRAME > 16) begin : g_bad_bits
    $error("BITS_PER_FRAME must lie in 2..16");
  end

  localparam logic [3:0] TICK_LAST = 4'(TICKS_PER_BIT - 1);
  localparam logic [3:0] BIT_LAST = 4'(BITS_PER_FRAME - 1);

  // ==========================================================
  // input synchronisers
  ipc_pkg::ipc_pins_t pins_raw;
  ipc_pkg::ipc_pins_t pins;
  logic [2:0] pins_q;

  assign pins_raw = '{clk16: SIXTEEN_TIMES_CLOCK_IN, host_in: HOST_TXD_IN, ir_in: IR_PULSE_IN};
  assign pins = ipc_pkg::ipc_pins_t'(pins_q);

  ipc_sync #(
    .W(3),
    .RST_VAL(3'h3)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .d(pins_raw),
    .q(pins_q)
  ); // R18

  // ==========================================================
  // state
  ipc_pkg::ipc_state_t s_r;
  ipc_pkg::ipc_state_t s_nxt;
  logic tick_ev;
  logic [8:0] lim_inc;
  logic pulse_win;

  assign tick_ev = pins.clk16 && !s_r.clk_prev; // R3
  // limiter runs over the whole pulse window and saturates, so a cut pulse cannot restart
  assign lim_inc = !(s_r.mode == ipc_pkg::IPC_TX && pulse_win && !s_r.bit_val) ? 9'h000
                   : (s_r.lim >= ipc_pkg::LIMIT_CYC) ? s_r.lim : s_r.lim + 9'h001; // R11
  assign pulse_win = s_r.tick >= ipc_pkg::TX_PULSE_FIRST && s_r.tick <= ipc_pkg::TX_PULSE_LAST;

  always_comb begin
    s_nxt = s_r;
    s_nxt.clk_prev = pins.clk16;
    case (s_r.mode)
      ipc_pkg::IPC_IDLE: begin
        s_nxt.tick = 4'h0;
        s_nxt.bits = 4'h0;
        if (!pins.ir_in) begin
          // receive wins: transmit is blocked while the link is busy
          s_nxt.mode = ipc_pkg::IPC_RX; // R16
          s_nxt.seen_low = 1'b1;
        end else if (!pins.host_in) begin
          s_nxt.mode = ipc_pkg::IPC_TX; // R1
          s_nxt.bit_val = 1'b0;
        end
      end
      ipc_pkg::IPC_TX, ipc_pkg::IPC_RX: begin
        if (tick_ev) begin
          s_nxt.tick = s_r.tick + 4'h1; // R4
          if (s_r.mode == ipc_pkg::IPC_TX && s_r.tick == ipc_pkg::TX_LATCH_TICK) begin
            s_nxt.bit_val = pins.host_in;
          end
          if (s_r.mode == ipc_pkg::IPC_RX) begin
            if (s_r.tick <= ipc_pkg::RX_WINDOW_LAST) begin
              s_nxt.seen_low = s_r.seen_low || !pins.ir_in; // R12
            end
            if (s_r.tick == ipc_pkg::RX_WINDOW_LAST) begin
              s_nxt.host_out = !(s_r.seen_low || !pins.ir_in); // R2 R13
            end
          end
          if (s_r.tick == TICK_LAST) begin
            s_nxt.tick = 4'h0; // R17
            s_nxt.bits = s_r.bits + 4'h1;
            s_nxt.seen_low = 1'b0;
            s_nxt.bit_val = 1'b1;
            if (s_r.bits == BIT_LAST) begin
              s_nxt.mode = ipc_pkg::IPC_IDLE;
              s_nxt.bits = 4'h0;
            end
          end
        end
      end
      default: begin
        s_nxt.mode = ipc_pkg::IPC_IDLE;
      end
    endcase
    s_nxt.lim = lim_inc;
    // pulse only in its window, for a low bit, with the link quiet, under the limiter
    s_nxt.ir_out = s_r.mode == ipc_pkg::IPC_TX && pulse_win && !s_r.bit_val
                   && pins.ir_in && lim_inc < ipc_pkg::LIMIT_CYC; // R9 R10 R11 R16
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= '{mode: ipc_pkg::IPC_IDLE, clk_prev: 1'b1, tick: 4'h0, bits: 4'h0,
               bit_val: 1'b1, seen_low: 1'b0, lim: 9'h000,
               ir_out: ipc_pkg::IR_OUT_RST, host_out: ipc_pkg::HOST_OUT_RST}; // R14 R15
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  assign HOST_RXD_OUT = s_r.host_out;
  assign IR_PULSE_OUT = s_r.ir_out;

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  pulse_window_a: assert property ($rose(IR_PULSE_OUT) |-> $past(s_r.tick) >= 4'h7 && $past(s_r.tick) <= 4'h9 && s_r.mode == ipc_pkg::IPC_TX) // R9
    else $error("ir pulse rose outside ticks 7..9");
  pulse_first_a: assert property ($rose(IR_PULSE_OUT) && $past(s_r.bits) == 4'h0 |-> $past(s_r.tick) == 4'h7 || !$past(pins.ir_in, 2)) // R1
    else $error("start bit pulse not at tick 7");
  high_bit_a: assert property ($past(s_r.bit_val) && $past(s_r.mode) == ipc_pkg::IPC_TX |-> !IR_PULSE_OUT) // R10
    else $error("ir pulse sent for a high bit");
  limiter_a: assert property (IR_PULSE_OUT |-> s_r.lim < 9'd500) // R11
    else $error("ir pulse exceeded limiter");
  half_duplex_a: assert property (!$past(pins.ir_in) |-> !IR_PULSE_OUT) // R16
    else $error("ir output driven while ir input low");
  rx_delay_a: assert property ($fell(HOST_RXD_OUT) |-> s_r.tick == 4'h4 && $past(tick_ev)) // R2
    else $error("host output fell not at tick 4");
  rx_hold_a: assert property ($changed(HOST_RXD_OUT) |-> s_r.tick == 4'h4 && s_r.mode == ipc_pkg::IPC_RX) // R13
    else $error("host output changed mid bit");
  tick_source_a: assert property ($changed(s_r.tick) && s_r.mode != ipc_pkg::IPC_IDLE |-> $past(tick_ev)) // R3
    else $error("tick counter moved without bit clock edge");
  bit_step_a: assert property ($changed(s_r.bits) && s_r.bits != 4'h0 |-> $past(s_r.tick) == 4'hf && s_r.tick == 4'h0) // R17
    else $error("bit advanced before sixteen ticks");
  frame_len_a: assert property (s_r.bits <= BIT_LAST) // R4
    else $error("frame longer than allowed");

  tx_frame_c: cover property (s_r.mode == ipc_pkg::IPC_TX ##1 s_r.mode == ipc_pkg::IPC_IDLE);
  rx_frame_c: cover property (s_r.mode == ipc_pkg::IPC_RX ##1 s_r.mode == ipc_pkg::IPC_IDLE);
  limiter_c: cover property (IR_PULSE_OUT ##1 !IR_PULSE_OUT && s_r.tick <= 4'h9 && s_r.lim == 9'd500);
  rx_low_c: cover property ($fell(HOST_RXD_OUT));

endmodule // ipc_codec

// *** verif/ipc_far_model.sv ***
`timescale 1ns/10ps

// host uart and ir transceiver on the far side of the codec
module ipc_far_model (
  // clock
  input wire logic CLK,
  // bit clock control
  input wire logic run,
  input wire logic [7:0] half,
  // pins toward the codec, plus the rise strobe for the testbench monitor
  output logic clk16,
  output logic rise,
  output logic host_txd,
  output logic ir_line
);
  logic [7:0] cnt;

  // ==========================================================
  // bit clock: still while stopped, rate set only between frames
  initial begin
    clk16 = 1'b0;
    rise = 1'b0;
    host_txd = 1'b1;
    ir_line = 1'b1;
    cnt = 8'h00;
  end

  always @(posedge CLK) begin
    rise <= 1'b0;
    if (!run) begin
      cnt <= 8'h00;
      clk16 <= 1'b0;
    end else if (cnt + 8'h01 >= half) begin
      cnt <= 8'h00;
      clk16 <= !clk16;
      rise <= !clk16;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // ==========================================================
  // frame sender: m[0] ir line, m[1] host line, changes mid tick
  task automatic send_frame(input logic [1:0] m, input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int b = 0; b < 10; b++) begin
      for (int t = 0; t < 16; t++) begin
        @(negedge clk16);
        @(posedge CLK);
        if (m[0]) ir_line <= !(fr[b] == 1'b0 && t < 3);
        if (m[1]) host_txd <= fr[b];
      end
    end
  endtask
endmodule // ipc_far_model

// *** verif/infrared_pulse_codec_tb.sv ***
`timescale 1ns/10ps

module infrared_pulse_codec_tb;
  logic CLK, RST_N, run, clr, clk16, rise, host_txd, ir_line, rxd, irout, prev_ir, armed;
  logic [7:0] half;
  logic [9:0] rx_word;
  logic [7:0] corner [3] = '{8'h00, 8'hff, 8'ha5};
  int fail_count, comparisons, cycles, seed, ticks, hi_cnt, pulses, first_tick, rx_first;

  ipc_codec u_ipc_codec (.CLK(CLK), .RST_N(RST_N), .CE(1'b1), .SIXTEEN_TIMES_CLOCK_IN(clk16),
    .HOST_TXD_IN(host_txd), .HOST_RXD_OUT(rxd), .IR_PULSE_IN(ir_line), .IR_PULSE_OUT(irout));
  ipc_far_model u_far (.CLK(CLK), .run(run), .half(half), .clk16(clk16), .rise(rise),
    .host_txd(host_txd), .ir_line(ir_line));

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // ==========================================================
  // checking
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic int pulse_width(input int h);
    return (6 * h < ipc_pkg::LIMIT_CYC_I) ? 6 * h : ipc_pkg::LIMIT_CYC_I;
  endfunction

  // ==========================================================
  // monitor: ticks counted from the first low on either input
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    prev_ir <= irout;
    if (clr) begin
      armed <= 1'b0;
      ticks <= 0;
      hi_cnt <= 0;
      pulses <= 0;
      first_tick <= -1;
      rx_first <= -1;
    end else begin
      if (host_txd === 1'b0 || ir_line === 1'b0) armed <= 1'b1;
      if (armed && rise) ticks <= ticks + 1;
      if (armed && rise && ticks[3:0] == 4'hb && ticks < 160) rx_word <= {rxd, rx_word[9:1]};
      if (irout === 1'b1) hi_cnt <= hi_cnt + 1;
      if (irout === 1'b1 && prev_ir !== 1'b1) pulses <= pulses + 1;
      if (irout === 1'b1 && prev_ir !== 1'b1 && first_tick < 0) first_tick <= ticks;
      if (armed && rxd === 1'b0 && rx_first < 0) rx_first <= ticks;
    end
    if (cycles == 80000) begin
      fail_count++;
      results();
    end
  end

  // ==========================================================
  // one frame with the bit clock stopped before and after it
  task automatic frame(input logic [1:0] m, input logic [7:0] d, input logic [7:0] h);
    int w, n, tol;
    w = pulse_width(h);
    n = 9 - $countones(d);
    tol = (w < 6 * h) ? n : 0;
    half <= h;
    run <= 1'b1;
    clr <= 1'b1;
    @(posedge CLK);
    clr <= 1'b0;
    u_far.send_frame(m, d);
    repeat (24) @(posedge CLK iff rise);
    run <= 1'b0;
    repeat (4) @(posedge CLK);
    if (m[0]) begin
      check(rx_first, 4);
      check(rx_word, {1'b1, d, 1'b0});
      check(pulses, 0);
    end else begin
      check(first_tick inside {7, 8}, 1'b1);
      check(pulses, n);
      check(hi_cnt >= n * w - tol && hi_cnt <= n * w + tol, 1'b1);
    end
  endtask

  initial begin
    seed = 32'h3c648713;
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    RST_N = 1'b0;
    run = 1'b0;
    clr = 1'b0;
    half = 8'h04;
    repeat (5) @(posedge CLK);
    check(rxd, 1'b1);
    check(irout, 1'b0);
    RST_N <= 1'b1;
    foreach (corner[i]) frame(2'b10, corner[i], 8'h04);
    repeat (4) frame(2'b10, 8'($random(seed)), 8'h04);
    frame(2'b10, 8'h00, 8'h64);
    foreach (corner[i]) frame(2'b01, corner[i], 8'h04);
    repeat (4) frame(2'b01, 8'($random(seed)), 8'h05);
    frame(2'b11, 8'($random(seed)), 8'h04);
    // reset in the middle of a pulse
    half <= 8'h04;
    run <= 1'b1;
    fork
      u_far.send_frame(2'b10, 8'h00);
    join_none
    wait (irout === 1'b1);
    @(posedge CLK);
    RST_N <= 1'b0;
    @(posedge CLK);
    check(irout, 1'b0);
    check(rxd, 1'b1);
    // bit clock keeps running, host line keeps moving: reset must keep the machine still
    repeat (40) @(posedge CLK);
    check(irout, 1'b0);
    check(rxd, 1'b1);
    results();
  end
endmodule // infrared_pulse_codec_tb
